/* File: verilog/asu_defines.vh */
/*
  Shared constants of the serial core: register indices, field positions,
  interrupt ident codes and timing counts.
  Assumes inclusion by bare name from the core module.
*/
`ifndef ASU_DEFINES_VH
`define ASU_DEFINES_VH
`define ASU_REG_DATA    3'h0
`define ASU_REG_IER     3'h1
`define ASU_REG_IIR     3'h2
`define ASU_REG_LCR     3'h3
`define ASU_REG_MCR     3'h4
`define ASU_REG_LSR     3'h5
`define ASU_REG_MSR     3'h6
`define ASU_REG_SCR     3'h7
`define ASU_IER_RX      0
`define ASU_IER_TX      1
`define ASU_IER_LS      2
`define ASU_IER_MS      3
`define ASU_MCR_DTR     0
`define ASU_MCR_RTS     1
`define ASU_MCR_OUTA    2
`define ASU_MCR_OUTB    3
`define ASU_MCR_LOOP    4
`define ASU_LCR_BREAK   6
`define ASU_LCR_DLAB    7
`define ASU_IIR_NONE    8'h01
`define ASU_IIR_LS      8'h06
`define ASU_IIR_RX      8'h04
`define ASU_IIR_TX      8'h02
`define ASU_IIR_MS      8'h00
`define ASU_BAUD_TICKS  5'h10
`define ASU_TX_ALL_EMPTY_DELAY  2'h2
`define ASU_STRETCH_NS  1000
`define ASU_CLK_NS      4
`define ASU_STRETCH_CYC ((`ASU_STRETCH_NS + `ASU_CLK_NS - 1) / `ASU_CLK_NS)
`endif

/* File: verilog/asu_core.v */
/*
  Serial transmitter/receiver core with an 8-bit parallel host port.
  Assumes bus inputs are synchronous to ref_clk_i, one-cycle baud tick
  at 16x the bit rate, and 8 data bits, no parity, one stop bit framing.
*/
`timescale 1ns/1ps
`include "asu_defines.vh"

// Contract
// - Standard mode copies status to readable stage regardless of chip select.
// - Standard mode: enabling transmit interrupt fires only if holding register empty.
// - Standard mode captures write data at the strobe trailing edge.
// - Loopback forces request, ready and both user outputs high.
// - Standard mode offers a read/write scratch byte at address seven.
// - Standard mode interrupt stays high while any interrupt pending.
// - Standard mode all-empty bit set when holding and shifter both empty.
// - Start bit begins sixteen baud ticks after holding register write.
// - Holding write strobe leading edge clears holding-empty and all-empty.
// - Receiver sets error and ready flags during the first stop bit.
// - All-empty sets two baud ticks after the final stop bit.
// - Standard mode modem control pins change on that register's strobe trailing edge.
// - Loopback routes serial output back into the receiver.
// - Legacy mode copies status only while not chip selected.
// - Legacy ident read clears transmit interrupt or stores a pending clear.
// - Legacy: enabling transmit interrupt fires at once regardless of holding unless a clear is pending.
// - Legacy interrupt line pulses low after each chip-selected read while any interrupt pending.
// - Legacy all-empty bit follows the shifter alone.
// - Legacy writes pass transparently while the strobe is active.
// - Legacy start bit lengthened about one microsecond, last stop shortened.
// - Legacy: buffer loaded after last data bit, overrun at stop.
module asu_core #(
  parameter STRETCH_CYC = `ASU_STRETCH_CYC
) (
  input  wire       ref_clk_i,
  input  wire       reset_n_i,
  input  wire       legacy_mode_i,
  input  wire       baud_tick_i,
  input  wire       cs_i,
  input  wire       rd_i,
  input  wire       wr_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  output reg        irq_line_o,
  output reg        txd_o,
  input  wire       rxd_i,
  output reg        rts_n_o,
  output reg        dtr_n_o,
  output reg        user_out_a_n_o,
  output reg        user_out_b_n_o,
  input  wire [3:0] modem_in_n_i
);

  reg       rst_s1_r;
  reg       rst_n_r;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  reg       legacy_r;
  reg       wr_d_r;
  reg [2:0] addr_d_r;
  reg [7:0] wdata_d_r;
  reg [7:0] ier_r;
  reg [7:0] lcr_r;
  reg [4:0] mcr_r;
  reg [7:0] scr_r;
  reg [7:0] thr_r;
  reg       thr_empty_r;
  reg       tsr_empty_r;
  reg       tx_all_empty_r;
  reg [1:0] tx_all_empty_cnt_r;
  reg [3:0] tx_state_r;
  reg [3:0] tx_tick_r;
  reg [7:0] tx_sh_r;
  reg [3:0] tx_bit_r;
  reg [9:0] stretch_r;
  reg       tx_irq_r;
  reg       tx_clr_pend_r;
  reg [7:0] rx_buffer_r;
  reg [7:0] rx_sh_r;
  reg [1:0] rx_state_r;
  reg [3:0] rx_tick_r;
  reg [3:0] rx_bit_r;
  reg       rx_ready_flag_r;
  reg       overrun_r;
  reg       frame_err_r;
  reg       break_r;
  reg [7:0] lsr_slave_r;
  reg [7:0] msr_slave_r;
  reg [3:0] msr_prev_r;
  reg [3:0] msr_delta_r;
  reg       tx_ser_r;
  reg       irq_gap_r;

  localparam TX_IDLE = 4'h0;
  localparam TX_WAIT = 4'h1;
  localparam TX_START = 4'h2;
  localparam TX_DATA = 4'h3;
  localparam TX_STOP = 4'h4;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  function hit;
    input [2:0] a;
    input [2:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  wire wr_lead  = wr_i & cs_i & ~wr_d_r;
  wire wr_trail = ~wr_i & wr_d_r;
  // Legacy mode writes while the strobe is active; standard on release.
  wire do_wr    = legacy_r ? (wr_i & cs_i) : wr_trail;
  wire [2:0] wa = legacy_r ? addr_i : addr_d_r;
  wire [7:0] wd = legacy_r ? wdata_i : wdata_d_r;
  wire dlab     = lcr_r[`ASU_LCR_DLAB];
  wire loop     = mcr_r[`ASU_MCR_LOOP];
  wire thr_lead = wr_lead & hit(addr_i, `ASU_REG_DATA) & ~dlab;
  wire thr_wr   = do_wr & hit(wa, `ASU_REG_DATA) & ~dlab;
  wire ier_wr   = do_wr & hit(wa, `ASU_REG_IER) & ~dlab;
  wire rd_hit   = rd_i & cs_i;
  wire iir_rd   = rd_hit & hit(addr_i, `ASU_REG_IIR);
  wire rbr_rd   = rd_hit & hit(addr_i, `ASU_REG_DATA) & ~dlab;
  wire lsr_rd   = rd_hit & hit(addr_i, `ASU_REG_LSR);
  wire msr_rd   = rd_hit & hit(addr_i, `ASU_REG_MSR);
  wire rx_in    = loop ? tx_ser_r : rxd_i;
  wire [3:0] modem_now = loop ? mcr_r[3:0] : ~modem_in_n_i;
  wire ls_pend  = ier_r[`ASU_IER_LS] & (overrun_r | frame_err_r | break_r);
  wire rx_pend  = ier_r[`ASU_IER_RX] & rx_ready_flag_r;
  wire ms_pend  = ier_r[`ASU_IER_MS] & (|msr_delta_r);
  wire tx_pend  = ier_r[`ASU_IER_TX] & tx_irq_r;
  wire any_pend = ls_pend | rx_pend | tx_pend | ms_pend;
  wire [7:0] iir_val = ls_pend ? `ASU_IIR_LS : rx_pend ? `ASU_IIR_RX :
                       tx_pend ? `ASU_IIR_TX : ms_pend ? `ASU_IIR_MS :
                       `ASU_IIR_NONE;
  wire tick_mid = baud_tick_i & (tx_tick_r == 4'hF);
  wire rx_mid   = baud_tick_i & (rx_tick_r == 4'h7);
  wire [7:0] lsr_live = {1'b0,
    legacy_r ? tsr_empty_r : tx_all_empty_r,
    thr_empty_r, break_r, frame_err_r, 1'b0, overrun_r, rx_ready_flag_r};
  wire [7:0] msr_live = {modem_now, msr_delta_r};

  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      legacy_r <= 1'b0;
      wr_d_r <= 1'b0;
      addr_d_r <= 3'h0;
      wdata_d_r <= 8'h00;
      ier_r <= 8'h00;
      lcr_r <= 8'h00;
      mcr_r <= 5'h00;
      scr_r <= 8'h00;
      thr_r <= 8'h00;
      thr_empty_r <= 1'b1;
      tsr_empty_r <= 1'b1;
      tx_all_empty_r <= 1'b1;
      tx_all_empty_cnt_r <= 2'h0;
      tx_state_r <= TX_IDLE;
      tx_tick_r <= 4'h0;
      tx_sh_r <= 8'h00;
      tx_bit_r <= 4'h0;
      stretch_r <= 10'h000;
      tx_irq_r <= 1'b0;
      tx_clr_pend_r <= 1'b0;
      rx_buffer_r <= 8'h00;
      rx_sh_r <= 8'h00;
      rx_state_r <= RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_ready_flag_r <= 1'b0;
      overrun_r <= 1'b0;
      frame_err_r <= 1'b0;
      break_r <= 1'b0;
      lsr_slave_r <= 8'h60;
      msr_slave_r <= 8'h00;
      msr_prev_r <= 4'h0;
      msr_delta_r <= 4'h0;
      tx_ser_r <= 1'b1;
      irq_gap_r <= 1'b0;
      rdata_o <= 8'h00;
      irq_line_o <= 1'b0;
      txd_o <= 1'b1;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      user_out_a_n_o <= 1'b1;
      user_out_b_n_o <= 1'b1;
    end else begin
      legacy_r <= legacy_mode_i;
      wr_d_r <= wr_i & cs_i;
      if (wr_i & cs_i) begin
        addr_d_r <= addr_i;
        wdata_d_r <= wdata_i;
      end
      if (do_wr) begin
        if (hit(wa, `ASU_REG_IER) & ~dlab)
          ier_r <= {4'h0, wd[3:0]};
        else if (hit(wa, `ASU_REG_LCR))
          lcr_r <= wd;
        else if (hit(wa, `ASU_REG_MCR))
          mcr_r <= wd[4:0];
        else if (hit(wa, `ASU_REG_SCR) & ~legacy_r)
          scr_r <= wd;
      end
      if (thr_wr)
        thr_r <= wd;
      // Outputs follow the register; loopback parks them inactive high.
      rts_n_o <= loop | ~mcr_r[`ASU_MCR_RTS];
      dtr_n_o <= loop | ~mcr_r[`ASU_MCR_DTR];
      user_out_a_n_o <= loop | ~mcr_r[`ASU_MCR_OUTA];
      user_out_b_n_o <= loop | ~mcr_r[`ASU_MCR_OUTB];

      // Transmit-empty interrupt source and its legacy pending clear.
      if (ier_wr & wd[`ASU_IER_TX] & ~ier_r[`ASU_IER_TX]) begin
        if (legacy_r)
          tx_irq_r <= ~tx_clr_pend_r;
        else
          tx_irq_r <= thr_empty_r;
        if (legacy_r)
          tx_clr_pend_r <= 1'b0;
      end else if (thr_lead) begin
        tx_irq_r <= 1'b0;
      end else if (iir_rd & legacy_r) begin
        if (tx_pend & (iir_val == `ASU_IIR_TX))
          tx_irq_r <= 1'b0;
        else
          tx_clr_pend_r <= 1'b1;
      end else if (iir_rd & (iir_val == `ASU_IIR_TX)) begin
        tx_irq_r <= 1'b0;
      end

      if (thr_lead) begin
        thr_empty_r <= 1'b0;
        tx_all_empty_r <= 1'b0;
        tx_all_empty_cnt_r <= 2'h0;
      end

      case (tx_state_r)
        TX_IDLE: begin
          tx_ser_r <= ~lcr_r[`ASU_LCR_BREAK];
          if (~thr_empty_r & ~thr_lead & ~wr_d_r) begin
            tx_state_r <= TX_WAIT;
            tx_tick_r <= 4'h0;
          end
        end
        TX_WAIT: begin
          // One bit time of delay before the start bit.
          if (baud_tick_i)
            tx_tick_r <= tx_tick_r + 4'h1;
          if (tick_mid) begin
            tx_sh_r <= thr_r;
            thr_empty_r <= 1'b1;
            tsr_empty_r <= 1'b0;
            if (legacy_r & ~tx_clr_pend_r)
              tx_irq_r <= 1'b1;
            else if (legacy_r)
              tx_clr_pend_r <= 1'b0;
            else
              tx_irq_r <= 1'b1;
            tx_ser_r <= 1'b0;
            tx_state_r <= TX_START;
            stretch_r <= legacy_r ? STRETCH_CYC[9:0] : 10'h000;
          end
        end
        TX_START: begin
          tx_ser_r <= 1'b0;
          // Legacy lookahead holds the start bit longer.
          if (stretch_r != 10'h000)
            stretch_r <= stretch_r - 10'h001;
          else begin
            if (baud_tick_i)
              tx_tick_r <= tx_tick_r + 4'h1;
            if (tick_mid) begin
              tx_state_r <= TX_DATA;
              tx_bit_r <= 4'h0;
            end
          end
        end
        TX_DATA: begin
          tx_ser_r <= tx_sh_r[0];
          if (baud_tick_i)
            tx_tick_r <= tx_tick_r + 4'h1;
          if (tick_mid) begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == 4'h7)
              tx_state_r <= TX_STOP;
          end
        end
        default: begin
          tx_ser_r <= 1'b1;
          if (baud_tick_i)
            tx_tick_r <= tx_tick_r + 4'h1;
          // Legacy stop ends one baud tick early to absorb the long start.
          if (tick_mid | (legacy_r & baud_tick_i &
              (tx_tick_r == 4'hE))) begin
            tsr_empty_r <= 1'b1;
            tx_tick_r <= 4'h0;
            tx_state_r <= TX_IDLE;
            tx_all_empty_cnt_r <= `ASU_TX_ALL_EMPTY_DELAY;
          end
        end
      endcase
      // Loopback parks the pin at mark so no character leaves the part.
      txd_o <= tx_ser_r | loop;
      if (tx_all_empty_cnt_r != 2'h0 & baud_tick_i & ~thr_lead) begin
        tx_all_empty_cnt_r <= tx_all_empty_cnt_r - 2'h1;
        if (tx_all_empty_cnt_r == 2'h1 & thr_empty_r)
          tx_all_empty_r <= 1'b1;
      end

      // Receiver, sampling at bit centre on the 16x tick.
      if (baud_tick_i)
        rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        RX_IDLE: if (~rx_in) begin
          rx_state_r <= RX_START;
          rx_tick_r <= 4'h0;
        end
        RX_START: if (rx_mid) begin
          rx_state_r <= rx_in ? RX_IDLE : RX_DATA;
          rx_bit_r <= 4'h0;
        end
        RX_DATA: if (rx_mid) begin
          rx_sh_r <= {rx_in, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == 4'h7) begin
            rx_state_r <= RX_STOP;
            if (legacy_r)
              rx_buffer_r <= {rx_in, rx_sh_r[7:1]};
          end
        end
        default: if (rx_mid) begin
          rx_state_r <= RX_IDLE;
          if (~legacy_r)
            rx_buffer_r <= rx_sh_r;
          overrun_r <= overrun_r | rx_ready_flag_r;
          frame_err_r <= ~rx_in;
          break_r <= ~rx_in & (rx_sh_r == 8'h00);
          rx_ready_flag_r <= 1'b1;
        end
      endcase
      if (rbr_rd & ~(rx_state_r == RX_STOP & rx_mid))
        rx_ready_flag_r <= 1'b0;
      if (lsr_rd & ~(rx_state_r == RX_STOP & rx_mid)) begin
        overrun_r <= 1'b0;
        frame_err_r <= 1'b0;
        break_r <= 1'b0;
      end

      msr_prev_r <= modem_now;
      if (msr_rd)
        msr_delta_r <= modem_now ^ msr_prev_r;
      else
        msr_delta_r <= msr_delta_r | (modem_now ^ msr_prev_r);

      if (~legacy_r | ~cs_i) begin
        lsr_slave_r <= lsr_live;
        msr_slave_r <= msr_live;
      end

      // Legacy line drops for one cycle after each chip-selected read of any register while an interrupt is pending.
      irq_gap_r <= legacy_r & rd_hit & any_pend;
      irq_line_o <= any_pend & ~(legacy_r & irq_gap_r);

      if (rd_hit) begin
        if (hit(addr_i, `ASU_REG_DATA))
          rdata_o <= rx_buffer_r;
        else if (hit(addr_i, `ASU_REG_IER))
          rdata_o <= ier_r;
        else if (hit(addr_i, `ASU_REG_IIR))
          rdata_o <= iir_val;
        else if (hit(addr_i, `ASU_REG_LCR))
          rdata_o <= lcr_r;
        else if (hit(addr_i, `ASU_REG_MCR))
          rdata_o <= {3'h0, mcr_r};
        else if (hit(addr_i, `ASU_REG_LSR))
          rdata_o <= lsr_slave_r;
        else if (hit(addr_i, `ASU_REG_MSR))
          rdata_o <= msr_slave_r;
        else
          rdata_o <= legacy_r ? 8'h00 : scr_r;
      end
    end
  end

endmodule // asu_core

/* File: dv/asu_core_sva.sv */
/*
  Checker for the serial core: reset idling, modem pin timing, loopback
  and legacy behaviour, read data holding.
  Assumes binding to asu_core and a host that keeps DLAB clear.
*/
`timescale 1ns/1ps
module asu_core_chk (
  input wire       ref_clk_i,
  input wire       reset_n_i,
  input wire       legacy_mode_i,
  input wire       baud_tick_i,
  input wire       cs_i,
  input wire       rd_i,
  input wire       wr_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  input wire       irq_line_o,
  input wire       txd_o,
  input wire       rxd_i,
  input wire       rts_n_o,
  input wire       dtr_n_o,
  input wire       user_out_a_n_o,
  input wire       user_out_b_n_o,
  input wire [3:0] modem_in_n_i
);
  reg  [7:0] mcr_d_r;
  wire [3:0] mdm_w = {user_out_b_n_o, user_out_a_n_o, rts_n_o, dtr_n_o};
  wire       wrs_w = cs_i && wr_i;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) mcr_d_r <= 8'h00;
    else if (wrs_w && addr_i == 3'h4) mcr_d_r <= wdata_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_mcr_norm;
    wrs_w && addr_i == 3'h4 && !legacy_mode_i && !wdata_i[4] ##1 !wrs_w;
  endsequence
  sequence s_mcr_loop;
    wrs_w && addr_i == 3'h4 && !legacy_mode_i && wdata_i[4] ##1 !wrs_w;
  endsequence
  sequence s_mcr_lead;
    (!wrs_w) [*3] ##1 (wrs_w && addr_i == 3'h4 && !legacy_mode_i);
  endsequence
  property p_rst_idle;
    $rose(reset_n_i) |-> txd_o && !irq_line_o && mdm_w == 4'hF;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  property p_mcr_set;
    s_mcr_norm |-> ##[0:2] mdm_w == ~mcr_d_r[3:0];
  endproperty
  a_mcr_set: assert property (p_mcr_set)
    else $error("modem pins missed the control write");
  property p_mcr_hold;
    s_mcr_lead |=> $stable(mdm_w);
  endproperty
  a_mcr_hold: assert property (p_mcr_hold)
    else $error("modem pins moved while strobe active");
  property p_loop_outs;
    s_mcr_loop |-> ##[0:2] mdm_w == 4'hF;
  endproperty
  a_loop_outs: assert property (p_loop_outs)
    else $error("modem pins not inactive in loopback");
  property p_leg_txirq;
    legacy_mode_i && wrs_w && addr_i == 3'h1 && wdata_i[1]
      |-> ##[1:3] irq_line_o;
  endproperty
  a_leg_txirq: assert property (p_leg_txirq)
    else $error("legacy transmit enable gave no interrupt");
  property p_rd_hold;
    !(rd_i && cs_i) |=> $stable(rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_leg_scr;
    legacy_mode_i && cs_i && rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00;
  endproperty
  a_leg_scr: assert property (p_leg_scr)
    else $error("scratch byte visible in legacy mode");
  property p_leg_mcr;
    legacy_mode_i && wrs_w && addr_i == 3'h4 && !wdata_i[4]
      |=> ##[0:1] mdm_w == ~mcr_d_r[3:0];
  endproperty
  a_leg_mcr: assert property (p_leg_mcr)
    else $error("legacy write not transparent");
endmodule // asu_core_chk

bind asu_core asu_core_chk u_chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
  .legacy_mode_i(legacy_mode_i), .baud_tick_i(baud_tick_i), .cs_i(cs_i),
  .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .irq_line_o(irq_line_o), .txd_o(txd_o),
  .rxd_i(rxd_i), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .user_out_a_n_o(user_out_a_n_o), .user_out_b_n_o(user_out_b_n_o),
  .modem_in_n_i(modem_in_n_i));

/* File: dv/asu_serial_peer.sv */
/*
  Far-end serial peer: sends one 8N1 frame on request, receives frames.
  Assumes a fixed bit time in clock cycles and an idle-high line.
*/
`timescale 1ns/1ps
module asu_serial_peer #(
  parameter BIT_CYC = 64
) (
  input  wire       clk_i,
  input  wire       txd_i,
  output reg        rxd_o,
  input  wire       send_i,
  input  wire [7:0] send_byte_i,
  output reg  [3:0] phase_o,
  output reg  [7:0] got_byte_o,
  output reg  [7:0] got_cnt_o
);
  integer   i;
  integer   j;
  reg [9:0] fr;
  reg [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    phase_o = 4'h0;
    got_byte_o = 8'h00;
    got_cnt_o = 8'h00;
  end
  // Phase counts 1 for start, 2 to 9 for data and 10 for stop.
  always @(posedge send_i) begin
    fr = {1'b1, send_byte_i, 1'b0};
    for (i = 0; i < 10; i = i + 1) begin
      @(posedge clk_i);
      rxd_o <= fr[i];
      phase_o <= i + 1;
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    phase_o <= 4'h0;
  end
  // Sampling at mid-bit keeps the peer tolerant of a slightly long start.
  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (j = 0; j < 8; j = j + 1) begin
      repeat (BIT_CYC) @(posedge clk_i);
      sh[j] = txd_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    got_byte_o <= sh;
    got_cnt_o <= got_cnt_o + 8'h01;
  end
endmodule // asu_serial_peer

/* File: dv/tb_async_serial_uart_core.sv */
/*
  Testbench of the serial core: register tasks, transmit, receive,
  loopback and legacy scenarios.
  Assumes a baud tick every 4 cycles, so one bit lasts 64 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_async_serial_uart_core;
  reg        ref_clk = 1'b0;
  reg        reset_n = 1'b0;
  reg        legacy  = 1'b0;
  reg        tick    = 1'b0;
  reg        cs      = 1'b0;
  reg        rd      = 1'b0;
  reg        wr      = 1'b0;
  reg  [2:0] addr    = 3'h0;
  reg  [7:0] wdata   = 8'h00;
  reg        snd     = 1'b0;
  reg  [7:0] sbyte   = 8'h00;
  reg  [1:0] tcnt    = 2'h0;
  reg  [7:0] v;
  reg  [7:0] e;
  reg  [7:0] c0;
  wire [7:0] rdata;
  wire [7:0] got_byte;
  wire [7:0] got_cnt;
  wire [3:0] phase;
  wire       irq, txd, rxd, rts_n, dtr_n, ua_n, ub_n;
  wire [3:0] mdm = {ub_n, ua_n, rts_n, dtr_n};
  integer    n_fail = 0;
  integer    n_tests = 0;
  integer    k;
  integer    d;
  time       t0;
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end
  asu_core #(.STRETCH_CYC(4)) dut (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .legacy_mode_i(legacy),
    .baud_tick_i(tick), .cs_i(cs), .rd_i(rd), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .irq_line_o(irq), .txd_o(txd),
    .rxd_i(rxd), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .user_out_a_n_o(ua_n),
    .user_out_b_n_o(ub_n), .modem_in_n_i(4'hF));
  asu_serial_peer #(.BIT_CYC(64)) peer (
    .clk_i(ref_clk), .txd_i(txd), .rxd_o(rxd), .send_i(snd),
    .send_byte_i(sbyte), .phase_o(phase), .got_byte_o(got_byte),
    .got_cnt_o(got_cnt));
  // Data stays on the bus until the next write, well past the strobe.
  task wr_reg(input [2:0] a, input [7:0] dt);
    begin
      @(negedge ref_clk); cs = 1'b1; wr = 1'b1; addr = a; wdata = dt;
      @(negedge ref_clk); cs = 1'b0; wr = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask
  task rd_reg(input [2:0] a, output [7:0] dt);
    begin
      @(negedge ref_clk); cs = 1'b1; rd = 1'b1; addr = a;
      @(negedge ref_clk); cs = 1'b0; rd = 1'b0;
      @(negedge ref_clk); dt = rdata;
    end
  endtask
  task wait_phase(input [3:0] p);
    begin
      k = 0;
      while (phase !== p && k < 2000) begin @(negedge ref_clk); k = k + 1; end
    end
  endtask
  task wait_got;
    begin
      k = 0;
      while (got_cnt === c0 && k < 1000) begin @(negedge ref_clk); k = k + 1; end
    end
  endtask
  task summarize;
    begin
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #(4 * 30000);
    n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("txd_idle", 1'b1, txd)
    `CHK("modem_idle", 4'hF, mdm)
    rd_reg(3'h5, v); `CHK("lsr_reset", 2'b11, v[6:5])
    for (k = 0; k < 4; k = k + 1) begin
      e = 8'h0F << k;
      wr_reg(3'h7, e); rd_reg(3'h7, v); `CHK("scratch", e, v)
    end
    wr_reg(3'h4, 8'h03); `CHK("mcr_on", 4'hC, mdm)
    wr_reg(3'h4, 8'h1F); `CHK("mcr_loop", 4'hF, mdm)
    wr_reg(3'h4, 8'h0C); `CHK("mcr_user", 4'h3, mdm)
    wr_reg(3'h4, 8'h00);
    $display("test registers done");
    c0 = got_cnt; t0 = $time;
    wr_reg(3'h0, 8'h3C);
    rd_reg(3'h5, v); `CHK("lsr_busy", 2'b00, v[6:5])
    wr_reg(3'h1, 8'h02); `CHK("irq_full", 1'b0, irq)
    k = 0;
    while (txd !== 1'b0 && k < 2000) begin @(negedge ref_clk); k = k + 1; end
    d = ($time - t0) / 4;
    `CHK("start_delay", 1'b1, (d >= 60 && d <= 72))
    repeat (8) @(negedge ref_clk);
    `CHK("irq_empty", 1'b1, irq)
    rd_reg(3'h2, v); `CHK("iir_tx", 8'h02, v)
    wr_reg(3'h1, 8'h00);
    wait_got; `CHK("tx_byte", 8'h3C, got_byte)
    rd_reg(3'h5, v); `CHK("tx_all_empty_early", 1'b0, v[6])
    repeat (45) @(negedge ref_clk);
    rd_reg(3'h5, v); `CHK("tx_all_empty_set", 2'b11, v[6:5])
    $display("test transmit done");
    sbyte = 8'h96; snd = 1'b1;
    wait_phase(4'h9); repeat (32) @(negedge ref_clk);
    rd_reg(3'h5, v); `CHK("dr_early", 1'b0, v[0])
    wait_phase(4'hA); repeat (40) @(negedge ref_clk);
    rd_reg(3'h5, v); `CHK("dr_stop", 1'b1, v[0])
    rd_reg(3'h0, v); `CHK("rx_byte", 8'h96, v)
    snd = 1'b0;
    $display("test receive done");
    c0 = got_cnt;
    wr_reg(3'h4, 8'h10); wr_reg(3'h0, 8'hC3);
    v = 8'h00;
    for (k = 0; k < 400 && v[0] !== 1'b1; k = k + 1) rd_reg(3'h5, v);
    rd_reg(3'h0, v); `CHK("loop_byte", 8'hC3, v)
    repeat (40) @(negedge ref_clk);
    `CHK("loop_quiet", c0, got_cnt)
    wr_reg(3'h4, 8'h00);
    $display("test loopback done");
    legacy = 1'b1;
    rd_reg(3'h7, v); `CHK("leg_scratch", 8'h00, v)
    wr_reg(3'h4, 8'h0C); `CHK("leg_mcr", 4'h3, mdm)
    wr_reg(3'h4, 8'h00);
    c0 = got_cnt;
    wr_reg(3'h0, 8'h11); wr_reg(3'h1, 8'h02);
    `CHK("leg_irq", 1'b1, irq)
    rd_reg(3'h2, v); `CHK("leg_iir", 8'h02, v)
    `CHK("leg_irq_clr", 1'b0, irq)
    wr_reg(3'h1, 8'h00);
    wait_got; `CHK("leg_byte", 8'h11, got_byte)
    sbyte = 8'h5A; snd = 1'b1;
    wait_phase(4'hA); repeat (8) @(negedge ref_clk);
    rd_reg(3'h0, v); `CHK("leg_rx_early", 8'h5A, v)
    snd = 1'b0;
    repeat (60) @(negedge ref_clk);
    $display("test legacy done");
    reset_n = 1'b0; repeat (2) @(negedge ref_clk);
    reset_n = 1'b1; legacy = 1'b0; repeat (3) @(negedge ref_clk);
    `CHK("rst2_irq", 1'b0, irq)
    rd_reg(3'h5, v); `CHK("rst2_lsr", 2'b11, v[6:5])
    $display("test second reset done");
    summarize;
  end
endmodule // tb_async_serial_uart_core
